// file: rtl/sbsr_params.svh
// Constants of the status byte and service request block.
// Assumes inclusion by bare name from the design files.
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH

// Status byte bit positions
`define SBSR_BIT_OPERATION_SUMMARY_BIT 7
`define SBSR_BIT_MSS 6
`define SBSR_BIT_ESB 5
`define SBSR_BIT_MAV 4
`define SBSR_BIT_QUESTIONABLE_SUMMARY_BIT 3

// Mask that hides bit 6 when forming the summary
`define SBSR_MSS_HIDE 8'hBF

// Nonvolatile word addresses: slots first, then settings
`define SBSR_SLOTS 4
`define SBSR_A_PSC 3'h4
`define SBSR_A_ESE 3'h5
`define SBSR_A_SRE 3'h6
`define SBSR_A_SEL 3'h7
`define SBSR_A_SLOT0 3'h0

// Reset values
`define SBSR_ENA_RST 8'h00
`define SBSR_PSC_RST 1'h1

// Power-on walk: step count of the last step
`define SBSR_BOOT_LAST 3'h5

`endif

// file: rtl/sbsr_pkg.sv
// Types shared by the status byte and service request block.
// Assumes nothing of its surroundings.
package sbsr_pkg;

   // Common commands as delivered by the bus parser
   typedef enum logic [3:0] {
      CMD_CLS,
      CMD_ESE_W,
      CMD_ESE_Q,
      CMD_ESR_Q,
      CMD_PSC_W,
      CMD_PSC_Q,
      CMD_RCL,
      CMD_RST,
      CMD_SAV,
      CMD_SRE_W,
      CMD_SRE_Q,
      CMD_STB_Q,
      CMD_TRG,
      CMD_GET,
      CMD_TST_Q,
      CMD_WAI
   } sbsr_cmd_type;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_IDLE,
      ST_RCL,
      ST_WAIT,
      ST_TEST
   } sbsr_state_type;

endpackage

// file: rtl/sbsr_nv_mem.sv
// Small memory standing in for the nonvolatile store.
// Assumes the array is kept across reset; read data are registered.
`timescale 1ns/1ns
`default_nettype none

module sbsr_nv_mem #(
   parameter int DW = 16,
   parameter int AW = 3
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // No reset on the array: contents survive power-on
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Read every cycle, one cycle of latency
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule

`default_nettype wire

// file: rtl/sbsr_event_reg.sv
// Sticky event register with clear on read or clear command.
// Assumes set inputs are one-cycle or level event pulses.
`timescale 1ns/1ns
`default_nettype none

module sbsr_event_reg #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] set_i,
   input wire logic clr_i,
   output logic [W-1:0] q_o
);

   // Set wins over clear, so no event is lost during a read
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q_o <= '0;
      end else begin
         q_o <= (q_o & ~{W{clr_i}}) | set_i;
      end
   end

endmodule

`default_nettype wire

// file: rtl/sbsr_top.sv
// Status byte, service request and common command logic.
// Assumes a parser delivers decoded commands and nrst_i is power-on.
// Functional notes
// - Clear-at-power-on set: both enables cleared at power-on
// - Clear-at-power-on off: enables restored from store
// - Setting query returns single digit 0 or 1
// - Setting write, and enable writes when off, commit
// - Recall restores all; aborts trigger, disables calibration
// - Selector names slot zero: recall it at power-on
// - Save writes state into one of four slots
// - Reset loads defaults and aborts trigger
// - Enabled status bits ORed into bit 6
// - Serial poll clears request, keeps master summary
// - Zero enable register never raises request
// - Status byte query returns byte, clears nothing
// - Summary bits clear only via their event registers
// - Message-available clears at power-on, clear, empty queue
// - Poll byte carries request bit in bit 6
// - Status byte bit layout, low three bits zero
// - Trigger only when bus is trigger source
// - Self-test answers 0 pass, 1 fail, logs
// - Wait blocks commands until done or device clear
// - Clear command clears events, status byte, error queue
// - Event summary is OR of enabled events
// - Event register read returns then clears it
`timescale 1ns/1ns
`default_nettype none
`include "sbsr_params.svh"

module sbsr_top #(
   parameter int SW = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire sbsr_pkg::sbsr_cmd_type cmd_code_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic [1:0] cmd_slot_i,
   output logic cmd_ready_o,
   output logic resp_valid_o,
   output logic [7:0] resp_data_o,
   input wire logic poll_i,
   output logic poll_valid_o,
   output logic [7:0] poll_data_o,
   output logic srq_o,
   input wire logic [7:0] std_event_set_i,
   input wire logic operation_summary_bit_i,
   input wire logic questionable_summary_bit_i,
   input wire logic queue_nonempty_i,
   output logic clear_status_o,
   input wire logic pending_i,
   input wire logic dev_clear_i,
   input wire logic trig_src_bus_i,
   input wire logic pon_sel_we_i,
   input wire logic recall_slot_zero_i,
   output logic trig_o,
   output logic trig_abort_o,
   output logic cal_off_o,
   output logic load_defaults_o,
   input wire logic [SW-1:0] state_i,
   output logic recall_valid_o,
   output logic [SW-1:0] recall_data_o,
   output logic selftest_start_o,
   input wire logic selftest_done_i,
   input wire logic selftest_fail_i,
   output logic error_log_o
);

   sbsr_pkg::sbsr_state_type st_q;
   logic [2:0] boot_q;
   logic psc_q;
   logic power_on_state_selector_q;
   logic [7:0] ese_q;
   logic [7:0] srm_q;
   logic rqs_q;
   logic mss_prev_q;
   logic mav_q;
   logic [7:0] ser_w;
   logic [SW-1:0] rd_data_w;
   logic [2:0] rd_addr;
   logic we;
   logic [2:0] waddr;
   logic [SW-1:0] wdata;
   logic acc;
   logic cls;
   logic esr_rd;
   logic esb_w;
   logic [7:0] stb_base;
   logic mss_w;
   logic mss_rise;
   logic [7:0] stb_w;
   logic rcl_fire;

   // Widen a byte to a store word
   function automatic logic [SW-1:0] to_word(input logic [7:0] b);
      to_word = {{(SW-8){1'b0}}, b};
   endfunction

   function automatic logic is_cmd(input sbsr_pkg::sbsr_cmd_type c);
      is_cmd = acc && (cmd_code_i == c);
   endfunction

   // Commands only taken while idle
   assign cmd_ready_o = (st_q == sbsr_pkg::ST_IDLE);
   assign acc = cmd_valid_i && cmd_ready_o;
   assign cls = is_cmd(sbsr_pkg::CMD_CLS);
   assign esr_rd = is_cmd(sbsr_pkg::CMD_ESR_Q);

   sbsr_event_reg #(
      .W(8)
   ) u_ser (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .set_i(std_event_set_i),
      .clr_i(cls | esr_rd),
      .q_o(ser_w)
   );

   sbsr_nv_mem #(
      .DW(SW),
      .AW(3)
   ) u_nv (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .we_i(we),
      .waddr_i(waddr),
      .wdata_i(wdata),
      .raddr_i(rd_addr),
      .rdata_o(rd_data_w)
   );

   assign esb_w = |(ser_w & ese_q);

   // byte layout; summaries follow their sources
   always_comb begin
      stb_base = 8'h00;
      stb_base[`SBSR_BIT_OPERATION_SUMMARY_BIT] = operation_summary_bit_i;
      stb_base[`SBSR_BIT_ESB] = esb_w;
      stb_base[`SBSR_BIT_MAV] = mav_q;
      stb_base[`SBSR_BIT_QUESTIONABLE_SUMMARY_BIT] = questionable_summary_bit_i;
   end

   // enabled bits ORed into bit 6
   assign mss_w = |(stb_base & srm_q & `SBSR_MSS_HIDE);
   assign mss_rise = mss_w && !mss_prev_q;

   always_comb begin
      stb_w = stb_base;
      stb_w[`SBSR_BIT_MSS] = mss_w;
   end

   assign srq_o = rqs_q && (|srm_q);

   // Store address: boot walk, recall slot, else slot 0
   always_comb begin
      rd_addr = `SBSR_A_SLOT0;
      if (st_q == sbsr_pkg::ST_BOOT) begin
         case (boot_q)
            3'h0: rd_addr = `SBSR_A_PSC;
            3'h1: rd_addr = `SBSR_A_ESE;
            3'h2: rd_addr = `SBSR_A_SRE;
            3'h3: rd_addr = `SBSR_A_SEL;
            default: rd_addr = `SBSR_A_SLOT0;
         endcase
      end else if (is_cmd(sbsr_pkg::CMD_RCL)) begin
         rd_addr = {1'b0, cmd_slot_i};
      end
   end

   // nonvolatile commits; one write per command
   always_comb begin
      we = 1'b0;
      waddr = `SBSR_A_PSC;
      wdata = '0;
      if (is_cmd(sbsr_pkg::CMD_PSC_W)) begin
         we = 1'b1;
         wdata = to_word({7'h00, cmd_data_i[0]});
      end else if (is_cmd(sbsr_pkg::CMD_ESE_W) && !psc_q) begin
         we = 1'b1;
         waddr = `SBSR_A_ESE;
         wdata = to_word(cmd_data_i);
      end else if (is_cmd(sbsr_pkg::CMD_SRE_W) && !psc_q) begin
         we = 1'b1;
         waddr = `SBSR_A_SRE;
         wdata = to_word(cmd_data_i);
      end else if (is_cmd(sbsr_pkg::CMD_SAV)) begin
         we = 1'b1;
         waddr = {1'b0, cmd_slot_i};
         wdata = state_i;
      end else if (pon_sel_we_i) begin
         // Selector changes come from the output subsystem
         we = 1'b1;
         waddr = `SBSR_A_SEL;
         wdata = to_word({7'h00, recall_slot_zero_i});
      end
   end

   // Sequencer: power-on walk, recall, wait and self-test
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= sbsr_pkg::ST_BOOT;
         boot_q <= 3'h0;
      end else begin
         case (st_q)
            sbsr_pkg::ST_BOOT: begin
               boot_q <= boot_q + 3'h1;
               if (boot_q == `SBSR_BOOT_LAST) begin
                  st_q <= sbsr_pkg::ST_IDLE;
               end
            end
            sbsr_pkg::ST_IDLE: begin
               if (is_cmd(sbsr_pkg::CMD_RCL)) begin
                  st_q <= sbsr_pkg::ST_RCL;
               end else if (is_cmd(sbsr_pkg::CMD_WAI)) begin
                  st_q <= sbsr_pkg::ST_WAIT;
               end else if (is_cmd(sbsr_pkg::CMD_TST_Q)) begin
                  st_q <= sbsr_pkg::ST_TEST;
               end
            end
            sbsr_pkg::ST_RCL: st_q <= sbsr_pkg::ST_IDLE;
            sbsr_pkg::ST_WAIT: begin
               // only completion or device clear ends it
               if (!pending_i || dev_clear_i) begin
                  st_q <= sbsr_pkg::ST_IDLE;
               end
            end
            sbsr_pkg::ST_TEST: begin
               if (selftest_done_i) begin
                  st_q <= sbsr_pkg::ST_IDLE;
               end
            end
            default: st_q <= sbsr_pkg::ST_IDLE;
         endcase
      end
   end

   // power-on clearing or restore of enables
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         psc_q <= `SBSR_PSC_RST;
         ese_q <= `SBSR_ENA_RST;
         srm_q <= `SBSR_ENA_RST;
      end else if (st_q == sbsr_pkg::ST_BOOT) begin
         if (boot_q == 3'h1) begin
            psc_q <= rd_data_w[0];
         end
         if (boot_q == 3'h2 && !psc_q) begin
            ese_q <= rd_data_w[7:0];
         end
         if (boot_q == 3'h3 && !psc_q) begin
            srm_q <= rd_data_w[7:0];
         end
      end else begin
         if (is_cmd(sbsr_pkg::CMD_PSC_W)) begin
            psc_q <= cmd_data_i[0];
         end
         if (is_cmd(sbsr_pkg::CMD_ESE_W)) begin
            ese_q <= cmd_data_i;
         end
         if (is_cmd(sbsr_pkg::CMD_SRE_W)) begin
            srm_q <= cmd_data_i;
         end
      end
   end

   // Selector restored at power-on, tracked afterwards
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         power_on_state_selector_q <= 1'b0;
      end else if (st_q == sbsr_pkg::ST_BOOT && boot_q == 3'h4) begin
         power_on_state_selector_q <= rd_data_w[0];
      end else if (pon_sel_we_i) begin
         power_on_state_selector_q <= recall_slot_zero_i;
      end
   end

   // message available: zero at power-on, cleared by clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mav_q <= 1'b0;
      end else begin
         mav_q <= queue_nonempty_i && !cls;
      end
   end

   // request on rising master summary; poll clears
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mss_prev_q <= 1'b0;
         rqs_q <= 1'b0;
      end else begin
         mss_prev_q <= mss_w;
         if (mss_rise) begin
            rqs_q <= 1'b1;
         end else if (poll_i || cls) begin
            rqs_q <= 1'b0;
         end
      end
   end

   // poll byte with request bit in bit 6
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         poll_valid_o <= 1'b0;
         poll_data_o <= 8'h00;
      end else begin
         poll_valid_o <= poll_i;
         if (poll_i) begin
            poll_data_o <= stb_base | {1'b0, rqs_q, 6'h00};
         end
      end
   end

   // Query answers; single-cycle response pulse
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         resp_valid_o <= 1'b0;
         resp_data_o <= 8'h00;
      end else begin
         resp_valid_o <= 1'b0;
         if (st_q == sbsr_pkg::ST_TEST && selftest_done_i) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= {7'h00, selftest_fail_i};
         end else if (acc) begin
            resp_valid_o <= 1'b1;
            case (cmd_code_i)
               sbsr_pkg::CMD_PSC_Q: resp_data_o <= {7'h00, psc_q};
               sbsr_pkg::CMD_ESE_Q: resp_data_o <= ese_q;
               sbsr_pkg::CMD_SRE_Q: resp_data_o <= srm_q;
               sbsr_pkg::CMD_STB_Q: resp_data_o <= stb_w;
               sbsr_pkg::CMD_ESR_Q: resp_data_o <= ser_w;
               default: resp_valid_o <= 1'b0;
            endcase
         end
      end
   end

   // Recall fires after command or, with the selector set, at end of power-on walk
   assign rcl_fire = (st_q == sbsr_pkg::ST_RCL) ||
      (st_q == sbsr_pkg::ST_BOOT && boot_q == `SBSR_BOOT_LAST && power_on_state_selector_q);

   // recall data out, trigger aborted, calibration off
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         recall_valid_o <= 1'b0;
         recall_data_o <= '0;
         cal_off_o <= 1'b0;
      end else begin
         recall_valid_o <= rcl_fire;
         cal_off_o <= rcl_fire;
         if (rcl_fire) begin
            recall_data_o <= rd_data_w;
         end
      end
   end

   // strobes: defaults, abort, trigger, clear, test
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         load_defaults_o <= 1'b0;
         trig_abort_o <= 1'b0;
         trig_o <= 1'b0;
         clear_status_o <= 1'b0;
         selftest_start_o <= 1'b0;
         error_log_o <= 1'b0;
      end else begin
         load_defaults_o <= is_cmd(sbsr_pkg::CMD_RST);
         trig_abort_o <= is_cmd(sbsr_pkg::CMD_RST) || rcl_fire;
         trig_o <= (is_cmd(sbsr_pkg::CMD_TRG) || is_cmd(sbsr_pkg::CMD_GET)) && trig_src_bus_i;
         // outer event registers and error queue
         clear_status_o <= cls;
         selftest_start_o <= is_cmd(sbsr_pkg::CMD_TST_Q);
         error_log_o <= st_q == sbsr_pkg::ST_TEST && selftest_done_i && selftest_fail_i;
      end
   end

   // Checks next to the logic they guard
   sequence s_poll_req;
      poll_i && !mss_rise;
   endsequence

   property p_no_srq_zero;
      @(posedge clk_i) disable iff (!nrst_i) (srm_q == 8'h00) |-> !srq_o;
   endproperty
   a_no_srq_zero: assert property (p_no_srq_zero) else $error("request with zero enable");

   property p_poll_clears;
      @(posedge clk_i) disable iff (!nrst_i) s_poll_req |=> !rqs_q && (mss_prev_q == $past(mss_w));
   endproperty
   a_poll_clears: assert property (p_poll_clears) else $error("poll did not clear request");

   property p_poll_byte;
      @(posedge clk_i) disable iff (!nrst_i)
         poll_i |=> poll_valid_o && poll_data_o == ($past(stb_base) | {1'b0, $past(rqs_q), 6'h00});
   endproperty
   a_poll_byte: assert property (p_poll_byte) else $error("poll byte wrong");

   // Rebuilt from the sources, not from the masked byte
   property p_mss_or;
      @(posedge clk_i) disable iff (!nrst_i)
         stb_w[`SBSR_BIT_MSS] == |({operation_summary_bit_i, esb_w, mav_q, questionable_summary_bit_i} &
            {srm_q[7], srm_q[5:3]});
   endproperty
   a_mss_or: assert property (p_mss_or) else $error("summary not OR of enabled bits");

   property p_rqs_rise;
      @(posedge clk_i) disable iff (!nrst_i) $rose(mss_w) |=> rqs_q;
   endproperty
   a_rqs_rise: assert property (p_rqs_rise) else $error("no request on rising summary");

   property p_esr_read;
      @(posedge clk_i) disable iff (!nrst_i)
         esr_rd |=> resp_data_o == $past(ser_w) && ser_w == $past(std_event_set_i);
   endproperty
   a_esr_read: assert property (p_esr_read) else $error("event read not cleared");

   property p_stb_query;
      @(posedge clk_i) disable iff (!nrst_i)
         is_cmd(sbsr_pkg::CMD_STB_Q) |=> resp_valid_o && resp_data_o == $past(stb_w);
   endproperty
   a_stb_query: assert property (p_stb_query) else $error("status byte query wrong");

   property p_wait_hold;
      @(posedge clk_i) disable iff (!nrst_i)
         st_q == sbsr_pkg::ST_WAIT && pending_i && !dev_clear_i |=> !cmd_ready_o;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("wait released early");

   property p_trg_src;
      @(posedge clk_i) disable iff (!nrst_i) is_cmd(sbsr_pkg::CMD_TRG) && !trig_src_bus_i |=> !trig_o;
   endproperty
   a_trg_src: assert property (p_trg_src) else $error("trigger without bus source");

   property p_pon_clear;
      @(posedge clk_i) disable iff (!nrst_i)
         st_q == sbsr_pkg::ST_BOOT && boot_q == `SBSR_BOOT_LAST && psc_q |=> ese_q == 8'h00 && srm_q == 8'h00;
   endproperty
   a_pon_clear: assert property (p_pon_clear) else $error("enables kept with clearing on");

endmodule

`default_nettype wire

// file: dv/sbsr_ctrl_model.sv
// Bus controller model: offers commands, reads answers, polls.
// Assumes a command is taken on an edge where ready is high.
`timescale 1ns/1ns
`default_nettype none

module sbsr_ctrl_model (
   input wire logic clk_i,
   input wire logic rdy_i,
   input wire logic rv_i,
   input wire logic [7:0] rd_i,
   input wire logic pv_i,
   input wire logic [7:0] pd_i,
   output logic val_o,
   output sbsr_pkg::sbsr_cmd_type code_o,
   output logic [7:0] data_o,
   output logic [1:0] slot_o,
   output logic poll_o,
   output logic dcl_o
);
   logic ok;
   logic [7:0] rd;

   // Idle levels from time zero
   initial begin
      val_o = 1'b0;
      code_o = sbsr_pkg::CMD_CLS;
      data_o = 8'h00;
      slot_o = 2'h0;
      poll_o = 1'b0;
      dcl_o = 1'b0;
   end

   // Hold the command until taken, then optionally await the answer
   task automatic send(input sbsr_pkg::sbsr_cmd_type c, input logic [7:0] d, input logic [1:0] s, input bit q);
      int n;
      @(posedge clk_i);
      val_o <= 1'b1;
      code_o <= c;
      data_o <= d;
      slot_o <= s;
      ok = 1'b0;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge clk_i);
         ok = rdy_i === 1'b1;
      end
      val_o <= 1'b0;
      data_o <= ~d; // No stale byte after release
      if (ok && q) begin
         ok = 1'b0;
         for (n = 0; n < 200 && !ok; n++) begin
            @(posedge clk_i);
            ok = rv_i === 1'b1;
         end
         rd = rd_i;
      end
   endtask

   // One-cycle poll request, answer seen a cycle later
   task automatic poll();
      int n;
      @(posedge clk_i);
      poll_o <= 1'b1;
      @(posedge clk_i);
      poll_o <= 1'b0;
      ok = 1'b0;
      for (n = 0; n < 8 && !ok; n++) begin
         ok = pv_i === 1'b1;
         rd = pd_i;
         if (!ok) begin
            @(posedge clk_i);
         end
      end
   endtask

   task automatic dev_clear();
      @(posedge clk_i);
      dcl_o <= 1'b1;
      @(posedge clk_i);
      dcl_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/status_byte_service_request_tb_top.sv
// Testbench of the status byte and service request block.
// Assumes the store keeps its words across nrst_i.
`timescale 1ns/1ns
`default_nettype none

module status_byte_service_request_tb_top;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cv, crdy, rv, pl, pv, srq, clr, pend, dcl, tsb, pwe, rsz, trg, abt, cal, def, recv, sts, sfl, err;
   logic op, qs, qne;
   logic sdn = 1'b0;
   logic [2:0] sdly = 3'h0;
   sbsr_pkg::sbsr_cmd_type cc;
   logic [7:0] cd, rd, pd, evs;
   logic [1:0] cs;
   logic [15:0] st, recd;
   int n[7];
   int mismatches = 0;
   int total_checks = 0;
   int i;

   always #4 clk_i = ~clk_i;

   sbsr_top #(.SW(16)) i_sbsr_top (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_valid_i(cv), .cmd_code_i(cc),
      .cmd_data_i(cd), .cmd_slot_i(cs), .cmd_ready_o(crdy), .resp_valid_o(rv), .resp_data_o(rd),
      .poll_i(pl), .poll_valid_o(pv), .poll_data_o(pd), .srq_o(srq), .std_event_set_i(evs),
      .operation_summary_bit_i(op), .questionable_summary_bit_i(qs), .queue_nonempty_i(qne),
      .clear_status_o(clr), .pending_i(pend), .dev_clear_i(dcl), .trig_src_bus_i(tsb), .pon_sel_we_i(pwe),
      .recall_slot_zero_i(rsz), .trig_o(trg), .trig_abort_o(abt), .cal_off_o(cal), .load_defaults_o(def),
      .state_i(st), .recall_valid_o(recv), .recall_data_o(recd), .selftest_start_o(sts),
      .selftest_done_i(sdn), .selftest_fail_i(sfl), .error_log_o(err));

   sbsr_ctrl_model i_sbsr_ctrl_model (.clk_i(clk_i), .rdy_i(crdy), .rv_i(rv), .rd_i(rd), .pv_i(pv),
      .pd_i(pd), .val_o(cv), .code_o(cc), .data_o(cd), .slot_o(cs), .poll_o(pl), .dcl_o(dcl));

   // Pulse counts per power cycle; self-test answers four cycles after its start pulse
   always @(posedge clk_i) begin
      sdly <= {sdly[1:0], sts};
      sdn <= sdly[2];
      for (int k = 0; k < 7; k++) begin
         n[k] <= !nrst_i ? 0 : n[k] + int'({err, clr, def, trg, abt, cal, recv} >> k & 7'h01);
      end
   end

   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask

   // A handshake that never completes ends the run
   task automatic guard(input logic ok);
      if (ok !== 1'b1) begin
         $display("ERROR handshake expected 1 seen 0");
         mismatches++;
         finish_test();
      end
   endtask

   task automatic cmd(input sbsr_pkg::sbsr_cmd_type c, input logic [7:0] d = 8'h00, input logic [1:0] s = 2'h0);
      i_sbsr_ctrl_model.send(c, d, s, 1'b0);
      guard(i_sbsr_ctrl_model.ok);
   endtask

   task automatic qry(input sbsr_pkg::sbsr_cmd_type c, input logic [7:0] e);
      i_sbsr_ctrl_model.send(c, 8'h00, 2'h0, 1'b1);
      guard(i_sbsr_ctrl_model.ok);
      check(c.name(), {8'h00, e}, {8'h00, i_sbsr_ctrl_model.rd});
   endtask

   task automatic poll(input logic [7:0] e);
      i_sbsr_ctrl_model.poll();
      guard(i_sbsr_ctrl_model.ok);
      check("poll byte", {8'h00, e}, {8'h00, i_sbsr_ctrl_model.rd});
   endtask

   // Power cycle, then wait out the boot walk
   task automatic rst();
      logic ok;
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      ok = 1'b0;
      for (int k = 0; k < 40 && !ok; k++) begin
         @(posedge clk_i);
         ok = crdy === 1'b1;
      end
      guard(ok);
      repeat (2) @(posedge clk_i);
   endtask

   task automatic evp(input logic [7:0] v);
      @(posedge clk_i);
      evs <= v;
      @(posedge clk_i);
      evs <= 8'h00;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      {pend, tsb, pwe, rsz, sfl, op, qs, qne} = 8'h00;
      evs = 8'h00;
      st = 16'h0000;
      rst();
      // Blank store: program settings and slots first
      cmd(sbsr_pkg::CMD_PSC_W, 8'h00);
      @(posedge clk_i);
      pwe <= 1'b1;
      rsz <= 1'b1;
      @(posedge clk_i);
      pwe <= 1'b0;
      for (i = 0; i < 4; i++) begin
         st <= 16'h5A00 + 16'(i);
         cmd(sbsr_pkg::CMD_SAV, 8'h00, 2'(i));
      end
      cmd(sbsr_pkg::CMD_SRE_W, 8'h20);
      cmd(sbsr_pkg::CMD_ESE_W, 8'h80);
      rst();
      check("boot recall", 16'h0001, 16'(n[0]));
      check("boot recall data", 16'h5A00, recd);
      check("boot cal off", 16'h0001, 16'(n[1]));
      qry(sbsr_pkg::CMD_SRE_Q, 8'h20);
      qry(sbsr_pkg::CMD_ESE_Q, 8'h80);
      qry(sbsr_pkg::CMD_PSC_Q, 8'h00);
      // Enabled event reaches summary, then request
      evp(8'h80);
      qry(sbsr_pkg::CMD_STB_Q, 8'h60);
      qry(sbsr_pkg::CMD_STB_Q, 8'h60);
      check("request line", 16'h0001, {15'h0000, srq});
      poll(8'h60);
      check("request after poll", 16'h0000, {15'h0000, srq});
      qry(sbsr_pkg::CMD_STB_Q, 8'h60);
      poll(8'h20);
      qry(sbsr_pkg::CMD_ESR_Q, 8'h80);
      qry(sbsr_pkg::CMD_STB_Q, 8'h00);
      qry(sbsr_pkg::CMD_ESR_Q, 8'h00);
      @(posedge clk_i);
      {op, qs, qne} <= 3'h7;
      repeat (2) @(posedge clk_i);
      qry(sbsr_pkg::CMD_STB_Q, 8'h98);
      qne <= 1'b0;
      repeat (2) @(posedge clk_i);
      qry(sbsr_pkg::CMD_STB_Q, 8'h88);
      cmd(sbsr_pkg::CMD_SRE_W, 8'h88);
      qry(sbsr_pkg::CMD_STB_Q, 8'hC8);
      check("request line", 16'h0001, {15'h0000, srq});
      cmd(sbsr_pkg::CMD_SRE_W, 8'h00);
      qry(sbsr_pkg::CMD_STB_Q, 8'h88);
      check("request off", 16'h0000, {15'h0000, srq});
      evp(8'h01);
      cmd(sbsr_pkg::CMD_CLS);
      repeat (2) @(posedge clk_i);
      check("clear pulse", 16'h0001, 16'(n[5]));
      qry(sbsr_pkg::CMD_ESR_Q, 8'h00);
      {op, qs} <= 2'h0;
      // Recall every slot
      for (i = 0; i < 4; i++) begin
         cmd(sbsr_pkg::CMD_RCL, 8'h00, 2'(i));
         repeat (3) @(posedge clk_i);
         check("recall data", 16'h5A00 + 16'(i), recd);
      end
      check("cal off count", 16'h0005, 16'(n[1]));
      check("recall count", 16'h0005, 16'(n[0]));
      cmd(sbsr_pkg::CMD_RST);
      repeat (2) @(posedge clk_i);
      check("defaults", 16'h0001, 16'(n[4]));
      check("abort count", 16'h0006, 16'(n[2]));
      cmd(sbsr_pkg::CMD_TRG);
      tsb <= 1'b1;
      cmd(sbsr_pkg::CMD_TRG);
      cmd(sbsr_pkg::CMD_GET);
      repeat (2) @(posedge clk_i);
      check("trigger count", 16'h0002, 16'(n[3]));
      qry(sbsr_pkg::CMD_TST_Q, 8'h00);
      sfl <= 1'b1;
      qry(sbsr_pkg::CMD_TST_Q, 8'h01);
      repeat (2) @(posedge clk_i);
      check("error log", 16'h0001, 16'(n[6]));
      // Wait ends by completion, then by device clear
      pend <= 1'b1;
      cmd(sbsr_pkg::CMD_WAI);
      repeat (5) @(posedge clk_i);
      check("ready in wait", 16'h0000, {15'h0000, crdy});
      pend <= 1'b0;
      qry(sbsr_pkg::CMD_PSC_Q, 8'h00);
      pend <= 1'b1;
      cmd(sbsr_pkg::CMD_WAI);
      i_sbsr_ctrl_model.dev_clear();
      qry(sbsr_pkg::CMD_PSC_Q, 8'h00);
      pend <= 1'b0;
      // Enable writes persist only while clearing is off
      cmd(sbsr_pkg::CMD_SRE_W, 8'h14);
      rst();
      qry(sbsr_pkg::CMD_SRE_Q, 8'h14);
      cmd(sbsr_pkg::CMD_PSC_W, 8'h01);
      cmd(sbsr_pkg::CMD_SRE_W, 8'h08);
      rst();
      qry(sbsr_pkg::CMD_SRE_Q, 8'h00);
      qry(sbsr_pkg::CMD_ESE_Q, 8'h00);
      qry(sbsr_pkg::CMD_PSC_Q, 8'h01);
      finish_test();
   end
endmodule
`default_nettype wire
